// >>> rbs_cfg.svh
// Constants for the reset and bootstrap sequencer
`ifndef RBS_CFG_SVH
`define RBS_CFG_SVH
// Input clock cycles per local clock period
`define RBS_DIV_RATIO 8
// Input clock cycles per quarter-clock
`define RBS_QUARTER_CYCLES 2
// Local clock periods during which chip select is ignored after reset release
`define RBS_CS_IGNORE_PERIODS 17
// Number of automatic refresh-only cycles after reset
`define RBS_REFRESH_CYCLES 8
// Local clock periods per refresh-only cycle
`define RBS_REFRESH_PERIODS 1
// Least reset low time in local clock periods (far side keeps it)
`define RBS_RESET_MIN_PERIODS 40
// Halt bit value after reset release with chip select high
`define RBS_HALT_HOSTBOOT 1'b1
// Halt bit value after reset release with chip select low
`define RBS_HALT_SELFBOOT 1'b0
`endif

// >>> rbs_pkg.sv
// Types for the reset and bootstrap sequencer
package rbs_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        RBS_IN_RESET = 2'b00,
        RBS_MASK = 2'b01,
        RBS_REFRESH = 2'b10,
        RBS_RUN = 2'b11
    } rbs_state_e;
    // Local clock pair
    typedef struct packed {
        logic one;
        logic two;
    } rbs_clocks_s;
endpackage

// >>> rbs_sequencer.sv
// Reset entry and exit sequencer with local clock divider
`timescale 1ns/1ns
`include "rbs_cfg.svh"

module rbs_sequencer
    import rbs_pkg::*;
#(
    parameter int DIV_RATIO = `RBS_DIV_RATIO,
    parameter int CS_IGNORE = `RBS_CS_IGNORE_PERIODS,
    parameter int REFRESH_CYCLES = `RBS_REFRESH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic host_chip_select_n,
    output logic local_clock_one,
    output logic local_clock_two,
    output logic halt_control_bit,
    output logic core_reset,
    output logic refresh_strobe,
    output logic host_select,
    output logic [1:0] seq_state
);

    // ****************************************************************
    // Clock divider
    // ****************************************************************
    // Phase counter width and the phase points at which the
    // two local clocks change; a quarter period is two input clocks
    localparam int PW = $clog2(DIV_RATIO);
    localparam logic [PW-1:0] PH_LAST = PW'(DIV_RATIO - 1);
    localparam logic [PW-1:0] PH_HALF = PW'(DIV_RATIO / 2);
    localparam logic [PW-1:0] PH_QTR = PW'(DIV_RATIO / 4);
    localparam logic [PW-1:0] PH_3QTR = PW'((3 * DIV_RATIO) / 4);

    logic [PW-1:0] phase; // Position in local period
    rbs_clocks_s clks; // Local clock pair
    logic fall_one; // Falling edge of local clock one is next

    // Phase counter wraps every eight input clocks
    // divide by eight
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase <= '0;
        end else if (phase == PH_LAST) begin
            phase <= '0;
        end else begin
            phase <= phase + PW'(1);
        end
    end

    // Local clock one high in first half, clock two a quarter later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Start as if phase seven had just passed, so the first
            // high phase of clock one is full length after reset
            clks.one <= 1'b1;
            clks.two <= 1'b0;
        end else begin
            clks.one <= (phase == PH_LAST) || (phase < PH_HALF - PW'(1));
            clks.two <= (phase >= PH_QTR - PW'(1)) && (phase < PH_3QTR - PW'(1));
        end
    end

    // Clock one drops shortly after this phase; inputs are
    // sampled here, standing in for the falling edge of clock one
    assign fall_one = (phase == PH_HALF - PW'(1));

    // Drive clocks out from flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            local_clock_one <= 1'b0;
            local_clock_two <= 1'b0;
        end else begin
            local_clock_one <= clks.one;
            local_clock_two <= clks.two;
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [1:0] rst_sync; // Reset synchroniser chain
    logic [1:0] cs_sync; // Chip select synchroniser chain

    // Only the second stage is read by the logic below; the first
    // stage may settle late and is kept away from everything else
    // Reset state treats the device as held in reset, chip select idle
    // two-stage flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rst_sync <= 2'h0;
            cs_sync <= 2'h3;
        end else begin
            rst_sync <= {rst_sync[0], reset_n};
            cs_sync <= {cs_sync[0], host_chip_select_n};
        end
    end

    // ****************************************************************
    // Edge sampling at local clock one fall
    // ****************************************************************
    logic rst_smp; // Reset level at last fall
    logic cs_smp; // Chip select level at last fall

    // Levels held from one fall to the next for reset edge detection and boot mode
    // sample on fall
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rst_smp <= 1'b0;
            cs_smp <= 1'b1;
        end else if (fall_one) begin
            rst_smp <= rst_sync[1];
            cs_smp <= cs_sync[1];
        end
    end

    // Reset release detected at this fall
    // First fall that sees the synchronised reset high after a low one
    logic rise_det;
    assign rise_det = fall_one && rst_sync[1] && !rst_smp;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Sequencer state and its down counter
    rbs_state_e state; // Current state
    logic [7:0] cnt; // Local periods or cycles remaining

    // Device reset seen low at a fall puts the sequencer back into
    // reset from any state, so a cut sequence restarts cleanly
    always_ff @(posedge sys_clk) begin
        if (rst || (fall_one && !rst_sync[1])) begin
            state <= RBS_IN_RESET;
            cnt <= 8'h00;
        end else begin
            case (state)
                // Wait for reset release
                RBS_IN_RESET: begin
                    if (rise_det) begin
                        state <= RBS_MASK;
                        cnt <= 8'(CS_IGNORE - 1);
                    end
                end
                RBS_MASK: begin
                    if (fall_one) begin
                        // Last ignored period ends, refresh begins
                        if (cnt == 8'h00) begin
                            state <= RBS_REFRESH;
                            cnt <= 8'(REFRESH_CYCLES - 1);
                        end else begin
                            cnt <= cnt - 8'h01;
                        end
                    end
                end
                RBS_REFRESH: begin
                    if (fall_one) begin
                        // Eighth refresh cycle done, host may select
                        if (cnt == 8'h00) begin
                            state <= RBS_RUN;
                        end else begin
                            cnt <= cnt - 8'h01;
                        end
                    end
                end
                // Stay running until reset is seen again
                RBS_RUN: begin
                    state <= RBS_RUN;
                end
                // Unused code returns to reset
                default: begin
                    state <= RBS_IN_RESET;
                end
            endcase
        end
    end

    // ****************************************************************
    // Boot mode and outputs
    // ****************************************************************
    // Chip select level captured at the fall before the release
    // decides the boot mode; it then stays until the next release
    // latch boot mode at release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halt_control_bit <= `RBS_HALT_HOSTBOOT;
        end else if (rise_det) begin
            halt_control_bit <= cs_smp ? `RBS_HALT_HOSTBOOT : `RBS_HALT_SELFBOOT;
        end
    end

    // Every output comes from a flop; status lags the state by one clock
    // Registered status outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_reset <= 1'b1;
            refresh_strobe <= 1'b0;
            host_select <= 1'b0;
            seq_state <= 2'h0;
        end else begin
            core_reset <= (state == RBS_IN_RESET);
            refresh_strobe <= (state == RBS_REFRESH) && fall_one;
            host_select <= (state == RBS_RUN) && !cs_sync[1];
            seq_state <= state;
        end
    end

endmodule // rbs_sequencer

// >>> rbs_seq_checker.sv
// Checker for the reset and bootstrap sequencer
`timescale 1ns/1ns
module rbs_seq_checker
    import rbs_pkg::*;
#(
    parameter int DIV_RATIO = 8, CS_IGNORE = 17, REFRESH_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic host_chip_select_n,
    input wire logic local_clock_one,
    input wire logic local_clock_two,
    input wire logic halt_control_bit,
    input wire logic core_reset,
    input wire logic refresh_strobe,
    input wire logic host_select,
    input wire logic [1:0] seq_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_CLK_PERIOD: assert property ($rose(local_clock_one) |=> !$rose(local_clock_one) [*7] ##1 $rose(local_clock_one))
        else $error("clock one period wrong");
    AST_CLK_HIGH: assert property ($rose(local_clock_one) |-> local_clock_one [*4] ##1 !local_clock_one)
        else $error("clock one duty wrong");
    AST_CLK_TWO: assert property ($rose(local_clock_one) |-> ##2 $rose(local_clock_two))
        else $error("clock two phase wrong");
    AST_MASK: assert property (disable iff (rst || !reset_n)
        (seq_state == 2'h1 && $past(seq_state) == 2'h0) |-> ##135 seq_state == 2'h1 ##1 seq_state == 2'h2)
        else $error("mask length wrong");
    AST_REFRESH: assert property (disable iff (rst || !reset_n)
        (seq_state == 2'h2 && $past(seq_state) == 2'h1) |-> ##63 seq_state == 2'h2 ##1 seq_state == 2'h3)
        else $error("refresh length wrong");
    AST_NO_SEL: assert property ((seq_state != 2'h3 && $past(seq_state) != 2'h3) |-> !host_select)
        else $error("select before run");
    AST_SEL_SYNC: assert property ($rose(host_select) |-> $past(host_chip_select_n, 3) == 1'b0)
        else $error("select without synced chip select");
    AST_HALT: assert property ((seq_state != 2'h0 && $past(seq_state) != 2'h0) |-> $stable(halt_control_bit))
        else $error("halt bit moved");
    AST_ENTER: assert property ($fell(reset_n) |-> ##[2:14] seq_state == 2'h0)
        else $error("reset entry late");
    AST_LEAVE: assert property ($rose(reset_n) |-> ##[2:14] seq_state == 2'h1)
        else $error("reset exit late");
    COV_RUN: cover property (seq_state == 2'h3);
    COV_STROBE: cover property (refresh_strobe);
    COV_SEL: cover property (host_select);
endmodule // rbs_seq_checker
bind rbs_sequencer rbs_seq_checker #(.DIV_RATIO(DIV_RATIO), .CS_IGNORE(CS_IGNORE), .REFRESH_CYCLES(REFRESH_CYCLES)) chk_inst (.*);

// >>> rbs_host_model.sv
// Host and reset source model
`timescale 1ns/1ns
module rbs_host_model (
    input wire logic sys_clk,
    input wire logic start,
    input wire logic self_boot,
    input wire logic host_req,
    output logic reset_n,
    output logic host_chip_select_n
);
    int cnt = 0;
    // Step count of one reset pulse
    always @(negedge sys_clk) cnt <= start ? 1 : (cnt != 0 && cnt < 330) ? cnt + 1 : 0;
    assign reset_n = !(cnt != 0 && cnt <= 320);
    assign host_chip_select_n = !(host_req || (self_boot && cnt != 0 && cnt <= 324));
endmodule // rbs_host_model

// >>> rbs_sequencer_tb.sv
// Self-checking bench for the reset and bootstrap sequencer
`timescale 1ns/1ns
`include "rbs_cfg.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module rbs_sequencer_tb;
    logic sys_clk = 0, rst = 1, start = 0, self_boot = 0, host_req = 0;
    logic reset_n, host_chip_select_n, local_clock_one, local_clock_two;
    logic halt_control_bit, core_reset, refresh_strobe, host_select;
    logic [1:0] seq_state;
    int n_mismatch = 0, tests_run = 0;
    rbs_sequencer rbs_sequencer_inst (.*);
    rbs_host_model rbs_host_model_inst (.*);
    initial forever #20 sys_clk = ~sys_clk;
    // Full reset pulse, then run state
    task automatic boot(input logic sb, input logic exp_halt);
        int n;
        n = 0;
        @(negedge sys_clk);
        start <= 1'b1;
        self_boot = sb;
        @(negedge sys_clk);
        start <= 1'b0;
        repeat (20) @(negedge sys_clk);
        `CHK("core reset", 1'b1, core_reset)
        for (int i = 0; i < 1000 && seq_state !== 2'h3; i++) begin
            @(negedge sys_clk);
            n += (refresh_strobe === 1'b1);
        end
        `CHK("state", 2'h3, seq_state)
        `CHK("strobes", 8, n)
        `CHK("halt", exp_halt, halt_control_bit)
        `CHK("select", 1'b0, host_select)
        `CHK("core reset off", 1'b0, core_reset)
    endtask
    // Chip select held low through mask and refresh is ignored
    task automatic masked;
        int n_core;
        int n_mask;
        int n_ref;
        int n_sel;
        n_core = 0;
        n_mask = 0;
        n_ref = 0;
        n_sel = 0;
        @(negedge sys_clk);
        self_boot = 1'b0;
        start <= 1'b1;
        @(negedge sys_clk);
        start <= 1'b0;
        for (int i = 0; i < 1000 && seq_state !== 2'h1; i++) begin
            @(negedge sys_clk);
            n_core += (core_reset === 1'b1);
        end
        host_req = 1'b1;
        for (int i = 0; i < 1000 && seq_state !== 2'h3; i++) begin
            n_mask += (seq_state === 2'h1);
            n_ref += (seq_state === 2'h2);
            n_sel += (host_select !== 1'b0);
            @(negedge sys_clk);
        end
        `CHK("reset length", `RBS_RESET_MIN_PERIODS * `RBS_DIV_RATIO, n_core)
        `CHK("mask length", `RBS_CS_IGNORE_PERIODS * `RBS_DIV_RATIO, n_mask)
        `CHK("refresh length", `RBS_REFRESH_CYCLES * `RBS_REFRESH_PERIODS * `RBS_DIV_RATIO, n_ref)
        `CHK("select masked", 0, n_sel)
        `CHK("select after refresh", 1'b1, host_select)
        `CHK("halt host boot", 1'b1, halt_control_bit)
        host_req = 1'b0;
        repeat (6) @(negedge sys_clk);
        `CHK("select released", 1'b0, host_select)
    endtask
    // Both local clocks run at an eighth of the input clock
    task automatic clocks;
        int n_one;
        int n_two;
        logic p_one;
        logic p_two;
        n_one = 0;
        n_two = 0;
        p_one = local_clock_one;
        p_two = local_clock_two;
        repeat (64) begin
            @(negedge sys_clk);
            n_one += (local_clock_one === 1'b1 && p_one === 1'b0);
            n_two += (local_clock_two === 1'b1 && p_two === 1'b0);
            p_one = local_clock_one;
            p_two = local_clock_two;
        end
        `CHK("clock one rises", 64 / `RBS_DIV_RATIO, n_one)
        `CHK("clock two rises", 64 / `RBS_DIV_RATIO, n_two)
    endtask
    // Host select once running
    task automatic pick;
        host_req = 1;
        repeat (6) @(negedge sys_clk);
        `CHK("select on", 1'b1, host_select)
        host_req = 0;
        repeat (6) @(negedge sys_clk);
        `CHK("select off", 1'b0, host_select)
    endtask
    task results;
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 0;
        boot(1'b1, 1'b0);
        pick;
        boot(1'b0, 1'b1);
        pick;
        masked;
        clocks;
        results;
    end
    initial begin
        #200000;
        n_mismatch++;
        results;
    end
endmodule // rbs_sequencer_tb
